/* File: core/cbta_map.svh */
`ifndef CBTA_MAP_SVH
`define CBTA_MAP_SVH

// register byte offsets on the wishbone bus
`define CBTA_ADR_CTRL 8'h00
`define CBTA_ADR_VALUE 8'h04
`define CBTA_ADR_STAT 8'h08
`define CBTA_ADR_MASK 8'h0c

// counter mode and measurement selections
`define CBTA_MODE_BIT_TIMING 2'h2
`define CBTA_SEL_DOM_DOM 3'h0
`define CBTA_SEL_DOM_REC 3'h1
`define CBTA_SEL_LOOP_DOM 3'h2
`define CBTA_SEL_LOOP_REC 3'h3
`define CBTA_SEL_SYNC_SMP 3'h4
`define CBTA_SEL_BIT_INFO 3'h5

// field positions and widths
`define CBTA_STAT_OVF_BIT 0
`define CBTA_MASK_IE_BIT 0
`define CBTA_BITLEN_W 12
`define CBTA_VALUE_W 16
`define CBTA_CTRL_W 5

// reset values
`define CBTA_CTRL_RST 5'h00
`define CBTA_VALUE_RST 16'h0000
`define CBTA_BITLEN_RST 12'h000
`define CBTA_RX_IDLE 1'b1

// consecutive done codes that mark an error frame
`define CBTA_ERR_RUN 2'h2

`endif

/* File: core/cbta_pkg.sv */
`default_nettype none
`include "cbta_map.svh"

package cbta_pkg;

   // frame segment code reported at each sample point
   typedef enum logic [1:0] {
      state_no_bit,
      state_first_bit,
      state_bit,
      state_done
   } cbta_bus_state_t;

   // software control word: mode in bits 4:3, selection in bits 2:0
   typedef struct packed {
      logic [1:0] counter_mode_select;
      logic [2:0] measurement_select;
   } cbta_ctrl_t;

   // layout of the counter value in the bit information selection
   typedef struct packed {
      logic tx_bit;
      logic rx_bit;
      cbta_bus_state_t bus_state;
      logic [`CBTA_BITLEN_W-1:0] bit_len;
   } cbta_bitinfo_t;

endpackage

`default_nettype wire

/* File: core/cbta_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for an asynchronous level
module cbta_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);

   logic meta_q;
   logic sync_q;

   // only the second stage is visible outside
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule // cbta_sync

`default_nettype wire

/* File: core/cbta_interval.sv */
`timescale 1ns/1ps
`default_nettype none

// free-running interval counter, restarted by a reference pulse
module cbta_interval #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   output logic [W-1:0] count_o
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic at_max;

   // saturate rather than wrap so a stalled line never reads short
   assign at_max = &cnt_q;
   assign cnt_d = restart_i ? '0 : (at_max ? cnt_q : cnt_q + 1'b1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // the cycle after the reference shows 0, so a capture reads elapsed minus one
   assign count_o = cnt_q;

endmodule // cbta_interval

`default_nettype wire

/* File: core/cbta_analyzer.sv */
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cbta_map.svh"

// Notes on behaviour
// - analysis runs only while the counter mode select holds 10
// - select 000: each dominant rx edge stores cycles since previous dominant edge
// - select 001: each recessive rx edge stores cycles since last dominant edge
// - select 010: rx dominant edge following tx dominant edge stores loop delay
// - select 011: rx recessive edge following tx recessive edge stores loop delay
// - select 100: each resync-eligible dominant edge stores cycles since last sample point
// - select 101: each sample point stores last bit time length in low twelve bits
// - select 101: bit 15 holds the transmitted value of the current bit
// - select 101: bit 14 holds the received sample of the current bit
// - select 101: bits 13:12 hold the frame segment code of the current bit
// - code 00 means idle, stuffing, SOF, SRR, CRC, delimiters, EOF start, IFS
// - code 01 means first bit of a segment or single-bit field
// - code 10 means a later bit inside a multi-bit segment
// - code 11 means ack slot, last EOF bit, error or overload frame
// - two or more consecutive code 11 sample points mean an error frame
// - every stored interval is the measured cycle count minus one
// - each counter update sets the overflow flag, software clears it
// - with the interrupt enable set, each update raises the interrupt
module cbta_analyzer
   import cbta_pkg::*;
#(
   parameter int ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // line and node timing signals
   input wire logic rx_pin_i,
   input wire logic tx_i,
   input wire logic bit_start_i,
   input wire logic sample_point_i,
   input wire logic resync_edge_i,
   input wire cbta_bus_state_t bus_state_i,
   // results
   output logic irq_o,
   output logic error_frame_o,
   output logic [`CBTA_VALUE_W-1:0] counter_value_o
);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic ack_q;
   logic [31:0] dat_q;
   cbta_ctrl_t ctrl_q;
   logic ovf_q;
   logic ovf_d;
   logic mask_q;
   logic [`CBTA_VALUE_W-1:0] value_q;

   // request decode; a write lands on the edge where ack is seen high
   wire req = wb_cyc_i & wb_stb_i;
   wire wr_take = req & ack_q & wb_we_i;
   wire hit_ctrl = (wb_adr_i == ADR_W'(`CBTA_ADR_CTRL));
   wire hit_value = (wb_adr_i == ADR_W'(`CBTA_ADR_VALUE));
   wire hit_stat = (wb_adr_i == ADR_W'(`CBTA_ADR_STAT));
   wire hit_mask = (wb_adr_i == ADR_W'(`CBTA_ADR_MASK));
   wire wr_ctrl = wr_take & hit_ctrl & wb_sel_i[0];
   wire wr_stat = wr_take & hit_stat & wb_sel_i[0];
   wire wr_mask = wr_take & hit_mask & wb_sel_i[0];
   wire ovf_clr = wr_stat & wb_dat_i[`CBTA_STAT_OVF_BIT];

   // read words; unmapped and misaligned addresses read as zero
   wire [31:0] rd_ctrl = {27'h0000000, ctrl_q};
   wire [31:0] rd_value = {16'h0000, value_q};
   wire [31:0] rd_stat = {31'h00000000, ovf_q};
   wire [31:0] rd_mask = {31'h00000000, mask_q};
   wire [31:0] rd_word = hit_ctrl ? rd_ctrl :
                         hit_value ? rd_value :
                         hit_stat ? rd_stat :
                         hit_mask ? rd_mask : 32'h00000000;

   // one wait state: ack follows the request by one edge and lasts one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         dat_q <= (req & ~ack_q) ? rd_word : dat_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   ack_pulse_a: assert property (ack_q |=> !ack_q)
      else $error("ack held longer than one cycle");
   ack_delay_a: assert property (req && !ack_q |=> ack_q)
      else $error("ack did not follow request by one cycle");

   // control and mask registers; writes to the value register are ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `CBTA_CTRL_RST;
         mask_q <= 1'b0;
      end else begin
         ctrl_q <= wr_ctrl ? cbta_ctrl_t'(wb_dat_i[`CBTA_CTRL_W-1:0]) : ctrl_q;
         mask_q <= wr_mask ? wb_dat_i[`CBTA_MASK_IE_BIT] : mask_q;
      end
   end

   // ---------------------------------------------------------------
   // line conditioning
   // ---------------------------------------------------------------
   logic rx_s;
   logic rx_prev_q;
   logic tx_prev_q;

   // the receive pin is asynchronous; the two stages add to every loop delay
   cbta_sync #(
      .RST_VAL(`CBTA_RX_IDLE)
   ) u_rx_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(rx_pin_i),
      .q_o(rx_s)
   );

   // previous levels for edge detection, idle is recessive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_prev_q <= `CBTA_RX_IDLE;
         tx_prev_q <= `CBTA_RX_IDLE;
      end else begin
         rx_prev_q <= rx_s;
         tx_prev_q <= tx_i;
      end
   end

   // edge pulses on the synchronised receive level and the transmit value
   wire rx_fall = rx_prev_q & ~rx_s;
   wire rx_rise = ~rx_prev_q & rx_s;
   wire tx_fall = tx_prev_q & ~tx_i;
   wire tx_rise = ~tx_prev_q & tx_i;

   // ---------------------------------------------------------------
   // interval counters, one per reference event
   // ---------------------------------------------------------------
   logic [`CBTA_VALUE_W-1:0] dom_cnt;
   logic [`CBTA_VALUE_W-1:0] txf_cnt;
   logic [`CBTA_VALUE_W-1:0] txr_cnt;
   logic [`CBTA_VALUE_W-1:0] smp_cnt;
   logic [`CBTA_VALUE_W-1:0] bit_cnt;

   cbta_interval #(.W(`CBTA_VALUE_W)) u_dom_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(rx_fall),
      .count_o(dom_cnt)
   );

   cbta_interval #(.W(`CBTA_VALUE_W)) u_txf_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(tx_fall),
      .count_o(txf_cnt)
   );

   cbta_interval #(.W(`CBTA_VALUE_W)) u_txr_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(tx_rise),
      .count_o(txr_cnt)
   );

   cbta_interval #(.W(`CBTA_VALUE_W)) u_smp_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(sample_point_i),
      .count_o(smp_cnt)
   );

   cbta_interval #(.W(`CBTA_VALUE_W)) u_bit_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(bit_start_i),
      .count_o(bit_cnt)
   );

   // ---------------------------------------------------------------
   // loop arming and bit length
   // ---------------------------------------------------------------
   logic arm_dom_q;
   logic arm_rec_q;
   logic [`CBTA_BITLEN_W-1:0] bitlen_q;

   // a loop edge counts only once after its transmitted edge, so echoes
   // of other nodes' edges are not taken for our own loop delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arm_dom_q <= 1'b0;
         arm_rec_q <= 1'b0;
      end else begin
         arm_dom_q <= tx_fall | (arm_dom_q & ~rx_fall);
         arm_rec_q <= tx_rise | (arm_rec_q & ~rx_rise);
      end
   end

   // length of the bit just ended, latched at each new bit start;
   // longer bits are cut to the field width
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bitlen_q <= `CBTA_BITLEN_RST;
      end else begin
         bitlen_q <= bit_start_i ? bit_cnt[`CBTA_BITLEN_W-1:0] : bitlen_q;
      end
   end

   // ---------------------------------------------------------------
   // capture selection
   // ---------------------------------------------------------------
   wire active = (ctrl_q.counter_mode_select == `CBTA_MODE_BIT_TIMING);
   wire [2:0] msel = ctrl_q.measurement_select;
   wire cap_dd = active & (msel == `CBTA_SEL_DOM_DOM) & rx_fall;
   wire cap_dr = active & (msel == `CBTA_SEL_DOM_REC) & rx_rise;
   wire cap_ld = active & (msel == `CBTA_SEL_LOOP_DOM) & rx_fall & arm_dom_q;
   wire cap_lr = active & (msel == `CBTA_SEL_LOOP_REC) & rx_rise & arm_rec_q;
   wire cap_ss = active & (msel == `CBTA_SEL_SYNC_SMP) & resync_edge_i;
   wire cap_bi = active & (msel == `CBTA_SEL_BIT_INFO) & sample_point_i;
   wire cap = cap_dd | cap_dr | cap_ld | cap_lr | cap_ss | cap_bi;

   // bit information word: tx, rx sample, segment code and bit length
   cbta_bitinfo_t info;
   assign info.tx_bit = tx_i;
   assign info.rx_bit = rx_s;
   assign info.bus_state = bus_state_i;
   assign info.bit_len = bitlen_q;

   // counters already hold elapsed minus one at the capture cycle
   wire [`CBTA_VALUE_W-1:0] cap_val = (cap_dd | cap_dr) ? dom_cnt :
                                      cap_ld ? txf_cnt :
                                      cap_lr ? txr_cnt :
                                      cap_ss ? smp_cnt :
                                      `CBTA_VALUE_W'(info);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         value_q <= `CBTA_VALUE_RST;
      end else begin
         value_q <= cap ? cap_val : value_q;
      end
   end

   assign counter_value_o = value_q;

   // dominant to dominant interval of five cycles reads four
   sequence dom_pair_s;
      cap_dd ##1 (!rx_fall && active && msel == `CBTA_SEL_DOM_DOM) [*4] ##1 cap_dd;
   endsequence
   dom_interval_a: assert property (dom_pair_s |=> value_q == 16'h0004)
      else $error("dominant interval not stored as count minus one");
   dom_rec_a: assert property (cap_dr |=> value_q == $past(dom_cnt))
      else $error("recessive edge capture wrong");
   loop_dom_a: assert property (cap_ld |=> value_q == $past(txf_cnt))
      else $error("dominant loop delay wrong");
   sync_smp_a: assert property (cap_ss |=> value_q == $past(smp_cnt))
      else $error("resync to sample point interval wrong");
   inactive_hold_a: assert property (!active |=> $stable(value_q))
      else $error("value changed outside bit timing mode");
   bit_info_a: assert property (cap_bi |=> value_q[15] == $past(tx_i) &&
                                value_q[14] == $past(rx_s) &&
                                value_q[13:12] == $past(bus_state_i))
      else $error("bit information fields wrong");

   // ---------------------------------------------------------------
   // error frame detection from the segment code
   // ---------------------------------------------------------------
   logic [1:0] done_run_q;
   logic [1:0] done_run_d;

   // codes 00, 01 and 10 come from the frame tracker as is; only the run
   // of done codes is judged here, counted at sample points of selection 101
   wire smp_done = cap_bi & (bus_state_i == state_done);
   wire smp_other = cap_bi & (bus_state_i != state_done);
   assign done_run_d = smp_other ? 2'h0 :
                       (smp_done & (done_run_q != `CBTA_ERR_RUN)) ? done_run_q + 2'h1 :
                       done_run_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_run_q <= 2'h0;
      end else begin
         done_run_q <= done_run_d;
      end
   end

   assign error_frame_o = (done_run_q == `CBTA_ERR_RUN);

   // remembers whether the previous sample point of selection 101 carried a
   // done code, so the check sees directly consecutive codes with any spacing
   logic prev_done_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_done_q <= 1'b0;
      end else begin
         prev_done_q <= cap_bi ? smp_done : prev_done_q;
      end
   end

   sequence two_done_s;
      smp_done && prev_done_q;
   endsequence
   err_frame_a: assert property (two_done_s |=> error_frame_o)
      else $error("error frame not flagged after two done codes");
   err_end_a: assert property (smp_other |=> !error_frame_o)
      else $error("error frame flag outlived a non done code");

   // ---------------------------------------------------------------
   // overflow flag and interrupt
   // ---------------------------------------------------------------
   // an update in the clearing cycle wins, so no capture goes unnoticed
   assign ovf_d = cap | (ovf_q & ~ovf_clr);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= ovf_d;
      end
   end

   // level output: stays high until software clears the flag or the interrupt enable
   assign irq_o = ovf_q & mask_q;

   ovf_set_a: assert property (cap |=> ovf_q)
      else $error("overflow flag not set by update");
   ovf_clear_a: assert property (ovf_clr && !cap |=> !ovf_q)
      else $error("overflow flag not cleared by write one");
   irq_raise_a: assert property (cap && mask_q && !wr_mask |=> irq_o)
      else $error("interrupt not raised on update");
   irq_quiet_a: assert property (!mask_q |-> !irq_o)
      else $error("interrupt raised while disabled");

endmodule // cbta_analyzer

`default_nettype wire

/* File: verification/cbta_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

// line seen through the transceiver: own tx echoed after a fixed loop delay,
// wired-and with a dominant level driven by some other node
module cbta_bus_model #(
   parameter int DLY = 4
) (
   input wire logic clk_i,
   input wire logic tx_i,
   input wire logic other_dom_i,
   output logic rx_o
);
   // starts recessive, the bus has a recessive idle level
   logic [DLY-1:0] line_q = '1;

   // carry the transmitted level along the loop delay
   always_ff @(posedge clk_i) begin
      line_q <= {line_q[DLY-2:0], tx_i};
   end

   // dominant wins on the wire
   assign rx_o = line_q[DLY-1] & ~other_dom_i;
endmodule // cbta_bus_model

`default_nettype wire

/* File: verification/tb_cbta_analyzer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cbta_map.svh"

module tb_cbta_analyzer import cbta_pkg::*; ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic tx = 1'b1;
   logic bs = 1'b0;
   logic sp = 1'b0;
   logic rs = 1'b0;
   logic odom = 1'b0;
   cbta_bus_state_t st = state_no_bit;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   logic err_o;
   logic rx_pin;
   logic [15:0] val_o;
   int err_total = 0;
   int check_count = 0;

   // 25 mhz clock
   always #20 clk_i = ~clk_i;

   cbta_bus_model #(.DLY(4)) bus (.clk_i(clk_i), .tx_i(tx), .other_dom_i(odom), .rx_o(rx_pin));

   cbta_analyzer #(.ADR_W(8)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rx_pin_i(rx_pin), .tx_i(tx), .bit_start_i(bs),
      .sample_point_i(sp), .resync_edge_i(rs), .bus_state_i(st), .irq_o(irq_o),
      .error_frame_o(err_o), .counter_value_o(val_o));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task stop_test;
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   // classic cycle, held until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      chk("ack", 1, wb_ack_o);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask

   // another node pulls the line dominant for d cycles, then releases for r
   task dom(input int d, input int r);
      odom <= 1'b1;
      tick(d);
      odom <= 1'b0;
      tick(r);
   endtask

   task t_regs;
      chk("irq after reset", 0, irq_o);
      chk("error frame after reset", 0, err_o);
      rd(`CBTA_ADR_CTRL, 0, "ctrl reset");
      rd(`CBTA_ADR_VALUE, 0, "value reset");
      rd(`CBTA_ADR_STAT, 0, "stat reset");
      rd(`CBTA_ADR_MASK, 0, "mask reset");
      wb(1'b1, `CBTA_ADR_CTRL, 32'hff);
      rd(`CBTA_ADR_CTRL, 32'h1f, "ctrl readback");
      wb(1'b1, `CBTA_ADR_VALUE, 32'hffff);
      rd(`CBTA_ADR_VALUE, 0, "value read only");
      rd(8'h10, 0, "unmapped");
   endtask

   task t_edges;
      wb(1'b1, `CBTA_ADR_CTRL, 32'h10);
      dom(3, 5);
      dom(2, 8);
      chk("dom to dom", 7, val_o);
      rd(`CBTA_ADR_VALUE, 7, "value reg");
      rd(`CBTA_ADR_STAT, 1, "overflow flag");
      // two dominant edges five cycles apart must read four
      dom(2, 3);
      dom(2, 8);
      chk("dom five apart", 4, val_o);
      wb(1'b1, `CBTA_ADR_CTRL, 32'h11);
      dom(6, 4);
      tick(2);
      chk("dom to rec", 5, val_o);
   endtask

   // loop delay: 4 in the line, 2 more between tx and rx edge detection
   task t_loop;
      wb(1'b1, `CBTA_ADR_CTRL, 32'h12);
      tx <= 1'b0;
      tick(12);
      chk("loop dom", 5, val_o);
      wb(1'b1, `CBTA_ADR_CTRL, 32'h13);
      tx <= 1'b1;
      tick(12);
      chk("loop rec", 5, val_o);
   endtask

   task t_sync;
      wb(1'b1, `CBTA_ADR_CTRL, 32'h14);
      sp <= 1'b1;
      tick(1);
      sp <= 1'b0;
      tick(5);
      rs <= 1'b1;
      tick(1);
      rs <= 1'b0;
      tick(2);
      chk("sample to sync", 5, val_o);
   endtask

   task t_info;
      wb(1'b1, `CBTA_ADR_CTRL, 32'h15);
      wb(1'b1, `CBTA_ADR_MASK, 1);
      odom <= 1'b1;
      bs <= 1'b1;
      tick(1);
      bs <= 1'b0;
      tick(9);
      bs <= 1'b1;
      tick(1);
      bs <= 1'b0;
      // every segment code, ending on one done code
      for (int i = 0; i < 4; i++) begin
         st <= cbta_bus_state_t'(i);
         sp <= 1'b1;
         tick(1);
         sp <= 1'b0;
         tick(2);
         chk("bit info", {1'b1, 1'b0, 2'(i), 12'h009}, val_o);
         chk("single done", 0, err_o);
      end
      sp <= 1'b1;
      tick(1);
      sp <= 1'b0;
      tick(2);
      chk("error frame", 1, err_o);
      st <= state_bit;
      sp <= 1'b1;
      tick(1);
      sp <= 1'b0;
      tick(2);
      chk("error frame end", 0, err_o);
      chk("irq", 1, irq_o);
      wb(1'b1, `CBTA_ADR_MASK, 0);
      chk("irq masked", 0, irq_o);
      rd(`CBTA_ADR_STAT, 1, "flag held");
      wb(1'b1, `CBTA_ADR_STAT, 1);
      rd(`CBTA_ADR_STAT, 0, "flag cleared");
      wb(1'b1, `CBTA_ADR_MASK, 1);
      chk("irq cleared", 0, irq_o);
      odom <= 1'b0;
      tick(4);
   endtask

   // inactive mode and a reserved selection leave value and flag alone
   task t_refuse;
      logic [15:0] v;
      v = val_o;
      wb(1'b1, `CBTA_ADR_CTRL, 32'h00);
      dom(3, 5);
      dom(3, 5);
      chk("mode off value", v, val_o);
      wb(1'b1, `CBTA_ADR_CTRL, 32'h16);
      dom(3, 5);
      dom(3, 5);
      chk("reserved value", v, val_o);
      rd(`CBTA_ADR_STAT, 0, "no flag");
   endtask

   // main sequence, reset held for two cycles
   initial begin
      tick(2);
      rst_i <= 1'b0;
      tick(3);
      t_regs;
      t_edges;
      t_loop;
      t_sync;
      t_info;
      t_refuse;
      stop_test;
   end

   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      stop_test;
   end
endmodule // tb_cbta_analyzer

`default_nettype wire
